// File: rtl/tsio_ports.sv
// Operation
// - Direction bit one drives, zero inputs
// - Read: latch for outputs, pin for inputs
// - Data bit sets input pull-up; outputs none
// - Timer direction resets by mode; data zero
// - Timer inputs take data bit when output
// - Timer outputs override direction, pull-up off
// - Expanded modes drive system clock pin except in hardware standby
// - Single-chip: clock pin input or clock
// - E-clock pin: clock or input only in expanded modes; single-chip plain port
// - Reset makes timer pins pulled-off inputs, bar the two clock pins in expanded modes
// - Hardware standby floats timer port, no pulls
// - Software standby keeps regs, holds clocks
// - Serial port six pins, resets 0xc0
// - Serial function switches its own pins
// - Transmit pins override, pull-up off
// - Receive pins pull-up if dir0 data1
// - Clock pins: out overrides, in pulls conditionally
// - Reset, hardware standby clear serial port
// - Software standby: serial pins plain port
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "tsio_map.svh"

module tsio_ports (
  input  wire logic                   CLK_SYS,      // System clock, 200 MHz
  input  wire logic                   SYS_RST,      // Synchronous reset, high
  input  wire logic [1:0]             MODE,         // Operating mode code
  input  wire logic                   HW_STANDBY,   // Hardware standby level
  input  wire logic                   SW_STANDBY,   // Software standby level
  input  wire logic [15:0]            ADDR,         // Register address
  input  wire logic [7:0]             WDATA,        // Write data
  input  wire logic                   WR,           // Write strobe
  input  wire logic                   RD,           // Read strobe
  output logic      [7:0]             RDATA,        // Read data, next cycle
  input  wire logic [1:0]             TMR_OUT_EN,   // Timer output selected
  input  wire logic [1:0]             TMR_OUT,      // Timer output levels
  input  wire logic                   SYSCLK_LVL,   // System clock level
  input  wire logic                   ECLK_LVL,     // E clock level
  output logic                        TMR0_CLK_IN,  // Timer 0 clock input
  output logic                        TMR0_RST_IN,  // Timer 0 reset input
  output logic                        TMR1_CLK_IN,  // Timer 1 clock input
  output logic                        TMR1_RST_IN,  // Timer 1 reset input
  output logic                        TMR_INIT,     // Timer controls init
  input  wire tsio_pkg::tsio_sci_ch_t SCI_CH [2],   // Serial channel requests
  output tsio_pkg::tsio_sci_in_t      SCI_IN,       // Serial pin levels
  output logic                        SCI_INIT,     // Serial controls init
  input  wire logic [7:0]             TPIN_IN,      // Timer port pin levels
  output tsio_pkg::tsio_tpins_t       TPIN,         // Timer port pin drive
  input  wire logic [5:0]             SPIN_IN,      // Serial port pin levels
  output tsio_pkg::tsio_spins_t       SPIN          // Serial port pin drive
);

  // ========================================================================
  // Helpers
  // Plain port pin: {oe_n, out, pull} from one direction and data bit
  function automatic logic [2:0] gp_pin(input logic dir, input logic dat);
    gp_pin = {~dir, dat, ~dir & dat};
  endfunction

  // Glitch filter: follow stage three only when stages two and three agree
  function automatic logic [7:0] agree(input logic [7:0] s2, input logic [7:0] s3,
                                       input logic [7:0] f);
    agree = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & f);
  endfunction

  // ========================================================================
  // State
  tsio_pkg::tsio_state_t st_q;  // Registered state
  tsio_pkg::tsio_state_t st_d;  // Next state

  logic expanded;               // Mode 1 or 2
  logic [7:0] t_rd;             // Timer port read view
  logic [7:0] s_rd;             // Serial port read view
  logic [7:0] s_f8;             // Serial filtered pins widened
  logic [7:0] s_agree;          // Serial filter result, widened to the helper
  logic [2:0] gp;               // Function result scratch
  logic       tx_on;            // Transmit claim scratch
  logic       rx_on;            // Receive claim scratch
  logic       ko_on;            // Clock-out claim scratch
  logic       ki_on;            // Clock-in claim scratch
  int         b;                // Pin index scratch

  assign expanded = (MODE == `TSIO_MODE_EXP1) || (MODE == `TSIO_MODE_EXP2);
  assign s_f8     = {2'h3, st_q.s_f};
  // Inputs show the pin, outputs the latch, timer and serial pins too
  assign t_rd     = (st_q.t_ddr & st_q.t_dr) | (~st_q.t_ddr & st_q.t_f);
  assign s_rd     = (st_q.s_ddr & st_q.s_dr) | (~st_q.s_ddr & s_f8);

  // ========================================================================
  // Next-state logic
  // Everything is computed here; pin drive is registered so it lags one cycle
  always_comb begin
    st_d  = st_q;
    s_agree = 8'h00;
    gp    = 3'h0;
    tx_on = 1'b0;
    rx_on = 1'b0;
    ko_on = 1'b0;
    ki_on = 1'b0;
    b     = 0;

    // Pin synchronisers; stage one feeds only stage two
    st_d.t_s1 = TPIN_IN;
    st_d.t_s2 = st_q.t_s1;
    st_d.t_s3 = st_q.t_s2;
    st_d.t_f  = agree(st_q.t_s2, st_q.t_s3, st_q.t_f);
    st_d.s_s1 = SPIN_IN;
    st_d.s_s2 = st_q.s_s1;
    st_d.s_s3 = st_q.s_s2;
    // A function result cannot be part-selected, so it lands in a wide scratch
    s_agree   = agree({2'h0, st_q.s_s2}, {2'h0, st_q.s_s3}, {2'h0, st_q.s_f});
    st_d.s_f  = s_agree[5:0];

    // Register writes; upper serial bits stay one
    if (WR) begin
      case (ADDR)
        `TSIO_TDDR_ADDR: st_d.t_ddr = WDATA;
        `TSIO_TDR_ADDR:  st_d.t_dr  = WDATA;
        `TSIO_SDDR_ADDR: st_d.s_ddr = WDATA | `TSIO_SREG_RST;
        `TSIO_SDR_ADDR:  st_d.s_dr  = WDATA | `TSIO_SREG_RST;
        default: ;
      endcase
    end

    // Register reads; direction registers are write-only
    st_d.rdata = `TSIO_UNMAPPED_READ;
    if (RD) begin
      case (ADDR)
        `TSIO_TDDR_ADDR: st_d.rdata = `TSIO_WO_READ;
        `TSIO_TDR_ADDR:  st_d.rdata = t_rd;
        `TSIO_SDDR_ADDR: st_d.rdata = `TSIO_WO_READ;
        `TSIO_SDR_ADDR:  st_d.rdata = s_rd;
        default:         st_d.rdata = `TSIO_UNMAPPED_READ;
      endcase
    end

    // Hardware standby clears the serial registers, not the timer ones
    if (HW_STANDBY) begin
      st_d.s_ddr = `TSIO_SREG_RST;
      st_d.s_dr  = `TSIO_SREG_RST;
    end

    // Control register initialisation requests to the peripherals
    st_d.tmr_init = HW_STANDBY | SW_STANDBY;
    st_d.sci_init = HW_STANDBY | SW_STANDBY;

    // Timer port: plain pins first, then overrides
    for (b = 0; b < 8; b++) begin
      gp = gp_pin(st_q.t_ddr[b], st_q.t_dr[b]);
      st_d.tp.oe_n[b] = gp[2];
      st_d.tp.out[b]  = gp[1];
      st_d.tp.pull[b] = gp[0];
    end

    // Timer outputs; standby initialises the timer so the override drops
    if (TMR_OUT_EN[0] && !SW_STANDBY) begin
      st_d.tp.oe_n[`TSIO_T0_OUT_BIT] = 1'b0;
      st_d.tp.out[`TSIO_T0_OUT_BIT]  = TMR_OUT[0];
      st_d.tp.pull[`TSIO_T0_OUT_BIT] = 1'b0;
    end
    if (TMR_OUT_EN[1] && !SW_STANDBY) begin
      st_d.tp.oe_n[`TSIO_T1_OUT_BIT] = 1'b0;
      st_d.tp.out[`TSIO_T1_OUT_BIT]  = TMR_OUT[1];
      st_d.tp.pull[`TSIO_T1_OUT_BIT] = 1'b0;
    end

    // System clock pin: never a general output
    if (expanded || st_q.t_ddr[`TSIO_SYSCLK_BIT]) begin
      st_d.tp.oe_n[`TSIO_SYSCLK_BIT] = 1'b0;
      st_d.tp.out[`TSIO_SYSCLK_BIT]  = SW_STANDBY | SYSCLK_LVL;
      st_d.tp.pull[`TSIO_SYSCLK_BIT] = 1'b0;
    end

    // E clock pin: in expanded modes clock out or input only
    if (expanded) begin
      st_d.tp.out[`TSIO_ECLK_BIT] = ~SW_STANDBY & ECLK_LVL;
    end

    // Hardware standby floats the whole timer port
    if (HW_STANDBY) begin
      st_d.tp.oe_n = 8'hff;
      st_d.tp.pull = 8'h00;
    end

    // Timer inputs see the data latch while the pin is an output
    st_d.tmr_in[0] = t_rd[`TSIO_T0_CLK_BIT];
    st_d.tmr_in[1] = t_rd[`TSIO_T0_RST_BIT];
    st_d.tmr_in[2] = t_rd[`TSIO_T1_CLK_BIT];
    st_d.tmr_in[3] = t_rd[`TSIO_T1_RST_BIT];

    // Serial port: plain pins first
    for (b = 0; b < 6; b++) begin
      gp = gp_pin(st_q.s_ddr[b], st_q.s_dr[b]);
      st_d.sp.oe_n[b] = gp[2];
      st_d.sp.out[b]  = gp[1];
      st_d.sp.pull[b] = gp[0];
    end

    // Serial claims; standby initialises the channels so they release
    for (b = 0; b < 2; b++) begin
      tx_on = SCI_CH[b].tx_en & ~SW_STANDBY;
      rx_on = SCI_CH[b].rx_en & ~SW_STANDBY;
      ko_on = SCI_CH[b].sck_out_en & ~SW_STANDBY;
      ki_on = SCI_CH[b].sck_in_en & ~SW_STANDBY & ~ko_on;
      if (tx_on) begin
        st_d.sp.oe_n[b*`TSIO_CH_STRIDE + `TSIO_TX_OFS] = 1'b0;
        st_d.sp.out[b*`TSIO_CH_STRIDE + `TSIO_TX_OFS]  = SCI_CH[b].tx_data;
        st_d.sp.pull[b*`TSIO_CH_STRIDE + `TSIO_TX_OFS] = 1'b0;
      end
      if (rx_on) begin
        st_d.sp.oe_n[b*`TSIO_CH_STRIDE + `TSIO_RX_OFS] = 1'b1;
        st_d.sp.pull[b*`TSIO_CH_STRIDE + `TSIO_RX_OFS] =
          ~st_q.s_ddr[b*`TSIO_CH_STRIDE + `TSIO_RX_OFS] &
          st_q.s_dr[b*`TSIO_CH_STRIDE + `TSIO_RX_OFS];
      end
      if (ko_on) begin
        st_d.sp.oe_n[b*`TSIO_CH_STRIDE + `TSIO_SCK_OFS] = 1'b0;
        st_d.sp.out[b*`TSIO_CH_STRIDE + `TSIO_SCK_OFS]  = SCI_CH[b].sck_out;
        st_d.sp.pull[b*`TSIO_CH_STRIDE + `TSIO_SCK_OFS] = 1'b0;
      end else if (ki_on) begin
        st_d.sp.oe_n[b*`TSIO_CH_STRIDE + `TSIO_SCK_OFS] = 1'b1;
        st_d.sp.pull[b*`TSIO_CH_STRIDE + `TSIO_SCK_OFS] =
          ~st_q.s_ddr[b*`TSIO_CH_STRIDE + `TSIO_SCK_OFS] &
          st_q.s_dr[b*`TSIO_CH_STRIDE + `TSIO_SCK_OFS];
      end
      st_d.sci.rx[b]  = st_q.s_f[b*`TSIO_CH_STRIDE + `TSIO_RX_OFS];
      st_d.sci.sck[b] = st_q.s_f[b*`TSIO_CH_STRIDE + `TSIO_SCK_OFS];
    end

    // Hardware standby floats the serial port
    if (HW_STANDBY) begin
      st_d.sp.oe_n = 6'h3f;
      st_d.sp.pull = 6'h00;
    end
  end

  // ========================================================================
  // State register
  // Reset is synchronous, so the mode-dependent direction value is legal here
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      st_q          <= '0;
      st_q.t_ddr    <= expanded ? `TSIO_TDDR_RST_EXP : `TSIO_TDDR_RST_SC;
      st_q.t_dr     <= `TSIO_TDR_RST;
      st_q.s_ddr    <= `TSIO_SREG_RST;
      st_q.s_dr     <= `TSIO_SREG_RST;
      st_q.tp.oe_n  <= 8'hff;
      st_q.sp.oe_n  <= 6'h3f;
      st_q.tmr_init <= 1'b1;
      st_q.sci_init <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // ========================================================================
  // Outputs, all from flip-flops
  assign RDATA       = st_q.rdata;
  assign TPIN        = st_q.tp;
  assign SPIN        = st_q.sp;
  assign TMR0_CLK_IN = st_q.tmr_in[0];
  assign TMR0_RST_IN = st_q.tmr_in[1];
  assign TMR1_CLK_IN = st_q.tmr_in[2];
  assign TMR1_RST_IN = st_q.tmr_in[3];
  assign TMR_INIT    = st_q.tmr_init;
  assign SCI_IN      = st_q.sci;
  assign SCI_INIT    = st_q.sci_init;

  // ========================================================================
  // Checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);

  sequence s_read_tdr;
    RD && (ADDR == `TSIO_TDR_ADDR);
  endsequence

  a_read_mix_view: assert property (s_read_tdr |=> RDATA == $past(t_rd))
    else $error("timer port read view wrong");

  a_no_pull_out: assert property ((~TPIN.oe_n & TPIN.pull) == 8'h00)
    else $error("pull-up on a driven timer pin");

  a_ddr_reset_val: assert property (disable iff (1'b0)
      $past(SYS_RST) |-> st_q.t_ddr == ($past(expanded) ? 8'h80 : 8'h00))
    else $error("timer direction reset value wrong");

  a_tmr_out_ovr: assert property (TMR_OUT_EN[0] && !SW_STANDBY && !HW_STANDBY
      |=> !TPIN.oe_n[1] && TPIN.out[1] == $past(TMR_OUT[0]) && !TPIN.pull[1])
    else $error("timer output override missing");

  a_sysclk_exp_on: assert property (expanded && !HW_STANDBY |=> !TPIN.oe_n[6])
    else $error("system clock not driven in expanded mode");

  a_hw_stby_float: assert property (HW_STANDBY [*2] |-> TPIN.oe_n == 8'hff &&
      TPIN.pull == 8'h00 && SPIN.oe_n == 6'h3f)
    else $error("port not floating in hardware standby");

  a_sw_eclk_low: assert property (SW_STANDBY && !HW_STANDBY && expanded
      |=> !TPIN.out[7] && TPIN.out[6] == !TPIN.oe_n[6])
    else $error("clock pins not held in software standby");

  a_sci_tx_ovr: assert property (SCI_CH[0].tx_en && !SW_STANDBY && !HW_STANDBY
      |=> !SPIN.oe_n[0] && !SPIN.pull[0] && SPIN.out[0] == $past(SCI_CH[0].tx_data))
    else $error("transmit pin override missing");

  a_sci_hw_clear: assert property (HW_STANDBY |=> st_q.s_ddr == 8'hc0 && st_q.s_dr == 8'hc0)
    else $error("serial registers not cleared");

  a_ddr_drives: assert property (!HW_STANDBY && SW_STANDBY
      |=> TPIN.oe_n[5:0] == ~$past(st_q.t_ddr[5:0]))
    else $error("timer pins not following direction");

endmodule
`default_nettype wire

// File: rtl/tsio_map.svh
`ifndef TSIO_MAP_SVH
`define TSIO_MAP_SVH
// ==========================================================================
// Register offsets
`define TSIO_TDDR_ADDR   16'hffb5
`define TSIO_TDR_ADDR    16'hffb7
`define TSIO_SDDR_ADDR   16'hffb8
`define TSIO_SDR_ADDR    16'hffba
// ==========================================================================
// Reset values
`define TSIO_TDDR_RST_EXP  8'h80
`define TSIO_TDDR_RST_SC   8'h00
`define TSIO_TDR_RST       8'h00
`define TSIO_SREG_RST      8'hc0
// Write-only registers read back as this value
`define TSIO_WO_READ       8'hff
// Unmapped addresses read as this value
`define TSIO_UNMAPPED_READ 8'h00
// ==========================================================================
// Operating mode codes
`define TSIO_MODE_EXP1   2'h1
`define TSIO_MODE_EXP2   2'h2
`define TSIO_MODE_SINGLE 2'h3
// ==========================================================================
// Timer-shared port pin positions
`define TSIO_T0_CLK_BIT  0
`define TSIO_T0_OUT_BIT  1
`define TSIO_T0_RST_BIT  2
`define TSIO_T1_CLK_BIT  3
`define TSIO_T1_OUT_BIT  4
`define TSIO_T1_RST_BIT  5
`define TSIO_SYSCLK_BIT  6
`define TSIO_ECLK_BIT    7
// Serial-shared port: channel c uses bits 3c (transmit), 3c+1, 3c+2
`define TSIO_TX_OFS      0
`define TSIO_RX_OFS      1
`define TSIO_SCK_OFS     2
`define TSIO_CH_STRIDE   3
`endif

// File: rtl/tsio_pkg.sv
package tsio_pkg;
  // ========================================================================
  // Pin bundles: output value, active-low output enable, pull-up request
  typedef struct packed {
    logic [7:0] out;   // Driven level
    logic [7:0] oe_n;  // Low while driving
    logic [7:0] pull;  // Pull-up on
  } tsio_tpins_t;

  typedef struct packed {
    logic [5:0] out;   // Driven level
    logic [5:0] oe_n;  // Low while driving
    logic [5:0] pull;  // Pull-up on
  } tsio_spins_t;

  // Requests from one serial channel
  typedef struct packed {
    logic tx_en;       // Transmit pin claimed
    logic tx_data;     // Transmit level
    logic rx_en;       // Receive pin claimed
    logic sck_out_en;  // Clock driven out
    logic sck_in_en;   // Clock received
    logic sck_out;     // Clock level out
  } tsio_sci_ch_t;

  // Values handed to the serial channels
  typedef struct packed {
    logic [1:0] rx;    // Receive level per channel
    logic [1:0] sck;   // Clock level per channel
  } tsio_sci_in_t;

  // Whole state of the port block
  typedef struct packed {
    logic [7:0]   t_ddr;     // Timer port direction
    logic [7:0]   t_dr;      // Timer port data
    logic [7:0]   s_ddr;     // Serial port direction
    logic [7:0]   s_dr;      // Serial port data
    logic [7:0]   t_s1;      // Timer pin sync stages
    logic [7:0]   t_s2;
    logic [7:0]   t_s3;
    logic [7:0]   t_f;       // Filtered timer pins
    logic [5:0]   s_s1;      // Serial pin sync stages
    logic [5:0]   s_s2;
    logic [5:0]   s_s3;
    logic [5:0]   s_f;       // Filtered serial pins
    tsio_tpins_t  tp;        // Timer pin drive
    tsio_spins_t  sp;        // Serial pin drive
    logic [7:0]   rdata;     // Read data
    logic [3:0]   tmr_in;    // Timer inputs: clk0, rst0, clk1, rst1
    tsio_sci_in_t sci;       // Serial inputs
    logic         tmr_init;  // Timer controls held initialised
    logic         sci_init;  // Serial controls held initialised
  } tsio_state_t;
endpackage

// File: tb/tsio_pins_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Board side of both ports: resolves every pin from all of its drivers
module tsio_pins_model (
  input  wire logic                  CLK_SYS,   // System clock
  input  wire tsio_pkg::tsio_tpins_t TPIN,      // Timer port drive
  input  wire tsio_pkg::tsio_spins_t SPIN,      // Serial port drive
  input  wire logic [7:0]            T_EXT,     // Board levels, timer port
  input  wire logic [7:0]            T_EXT_EN,  // Board drives timer pin
  input  wire logic [5:0]            S_EXT,     // Board levels, serial port
  input  wire logic [5:0]            S_EXT_EN,  // Board drives serial pin
  output logic      [7:0]            TPIN_IN,   // Resolved timer pin levels
  output logic      [5:0]            SPIN_IN    // Resolved serial pin levels
);
  logic [7:0] wander_q = 8'h5a;  // Level of a line nobody holds

  // A floating line toggles so a missing pull-up never reads as a match
  always_ff @(posedge CLK_SYS) begin
    wander_q <= ~wander_q;
  end

  // Device drive wins, then board input, then pull-up, else wander
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      TPIN_IN[i] = !TPIN.oe_n[i] ? TPIN.out[i] :
                   T_EXT_EN[i] ? T_EXT[i] :
                   TPIN.pull[i] ? 1'b1 : wander_q[i];
    end
    for (int i = 0; i < 6; i++) begin
      SPIN_IN[i] = !SPIN.oe_n[i] ? SPIN.out[i] :
                   S_EXT_EN[i] ? S_EXT[i] :
                   SPIN.pull[i] ? 1'b1 : wander_q[i];
    end
  end
endmodule

`default_nettype wire

// File: tb/tsio_ports_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "tsio_map.svh"

module tsio_ports_tb_top;
  logic                    clk_sys, sys_rst, wr, rd;  // Clock, reset, strobes
  logic                    hw_sb, sw_sb;              // Standby levels
  logic                    sysclk_lvl, eclk_lvl;      // Clock levels to pins
  logic                    t0c, t0r, t1c, t1r;        // Timer inputs
  logic                    tmr_init, sci_init;        // Control init flags
  logic [1:0]              mode, tmr_out_en, tmr_out; // Mode, timer outputs
  logic [15:0]             addr;                      // Register address
  logic [7:0]              wdata, rdata;              // Bus data
  logic [7:0]              t_ext, t_ext_en, tpin_in;  // Timer pin board side
  logic [5:0]              s_ext, s_ext_en, spin_in;  // Serial pin board side
  tsio_pkg::tsio_sci_ch_t  sci_ch [2];                // Serial requests
  tsio_pkg::tsio_sci_in_t  sci_in;                    // Serial pin levels
  tsio_pkg::tsio_tpins_t   tpin;                      // Timer pin drive
  tsio_pkg::tsio_spins_t   spin;                      // Serial pin drive
  int                      fails, n_tests;            // Counters

  tsio_ports dut (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .MODE(mode),
    .HW_STANDBY(hw_sb), .SW_STANDBY(sw_sb), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .TMR_OUT_EN(tmr_out_en), .TMR_OUT(tmr_out),
    .SYSCLK_LVL(sysclk_lvl), .ECLK_LVL(eclk_lvl), .TMR0_CLK_IN(t0c),
    .TMR0_RST_IN(t0r), .TMR1_CLK_IN(t1c), .TMR1_RST_IN(t1r), .TMR_INIT(tmr_init),
    .SCI_CH(sci_ch), .SCI_IN(sci_in), .SCI_INIT(sci_init), .TPIN_IN(tpin_in),
    .TPIN(tpin), .SPIN_IN(spin_in), .SPIN(spin));

  tsio_pins_model board (.CLK_SYS(clk_sys), .TPIN(tpin), .SPIN(spin),
    .T_EXT(t_ext), .T_EXT_EN(t_ext_en), .S_EXT(s_ext), .S_EXT_EN(s_ext_en),
    .TPIN_IN(tpin_in), .SPIN_IN(spin_in));

  // ========================================================================
  // Clock and shared tasks
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Compare one value, report a mismatch at once
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask

  // Let n edges pass, then step off the edge so outputs have settled
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic do_reset(input logic [1:0] m);
    @(posedge clk_sys);
    mode <= m;
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    wait_n(8);
  endtask

  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // A hang is cut short well past the hundred-odd cycles the tests need
  initial begin
    #20000;
    fails++;
    stop_test();
  end

  // ========================================================================
  // Tests
  initial begin
    {sys_rst, wr, rd, hw_sb, sw_sb, eclk_lvl} = '0;
    {tmr_out_en, tmr_out, addr, wdata} = '0;
    {mode, sysclk_lvl} = 3'b111;
    // Hold reset from time zero so no edge sees unknown state unguarded
    sys_rst = 1'b1;
    {t_ext, t_ext_en, s_ext, s_ext_en} = {8'ha5, 8'hff, 6'h2a, 6'h3f};
    sci_ch[0] = '0;
    sci_ch[1] = '0;
    fails = 0;
    n_tests = 0;
    do_reset(`TSIO_MODE_SINGLE);
    chk(tpin.oe_n, 8'hff);
    chk(tpin.pull, 8'h00);
    chk({2'b00, spin.oe_n}, 8'h3f);
    rd_chk(`TSIO_TDR_ADDR, 8'ha5);
    rd_chk(`TSIO_TDDR_ADDR, `TSIO_WO_READ);
    rd_chk(`TSIO_SDR_ADDR, 8'hea);
    rd_chk(`TSIO_SDDR_ADDR, `TSIO_WO_READ);
    rd_chk(16'hffb6, `TSIO_UNMAPPED_READ);
    $display("Test reset mode 3 done");
    wr_reg(`TSIO_TDDR_ADDR, 8'h3f);
    wr_reg(`TSIO_TDR_ADDR, 8'h15);
    wait_n(2);
    chk(tpin.oe_n, 8'hc0);
    chk(tpin.out & 8'h3f, 8'h15);
    chk(tpin.pull, 8'h00);
    chk({4'h0, t0c, t0r, t1c, t1r}, 8'h0c);
    rd_chk(`TSIO_TDR_ADDR, 8'h95);
    wr_reg(`TSIO_TDDR_ADDR, 8'h00);
    wr_reg(`TSIO_TDR_ADDR, 8'hff);
    t_ext_en <= 8'h00;
    wait_n(8);
    chk(tpin.pull, 8'hff);
    rd_chk(`TSIO_TDR_ADDR, 8'hff);
    t_ext_en <= 8'hff;
    wait_n(8);
    chk({4'h0, t0c, t0r, t1c, t1r}, 8'h0d);
    tmr_out_en <= 2'b11;
    tmr_out <= 2'b10;
    wait_n(2);
    chk(tpin.oe_n & 8'h12, 8'h00);
    chk(tpin.out & 8'h12, 8'h10);
    chk(tpin.pull & 8'h12, 8'h00);
    tmr_out_en <= 2'b00;
    wr_reg(`TSIO_TDDR_ADDR, 8'hc0);
    wr_reg(`TSIO_TDR_ADDR, 8'h00);
    wait_n(2);
    chk(tpin.oe_n, 8'h3f);
    chk({6'h00, tpin.out[7:6]}, 8'h01);
    $display("Test timer port mode 3 done");
    do_reset(`TSIO_MODE_EXP1);
    chk(tpin.oe_n, 8'h3f);
    chk(tpin.pull, 8'h00);
    wr_reg(`TSIO_TDDR_ADDR, 8'h00);
    wr_reg(`TSIO_TDR_ADDR, 8'hff);
    wait_n(2);
    chk(tpin.oe_n, 8'hbf);
    chk(tpin.pull, 8'hbf);
    wr_reg(`TSIO_TDDR_ADDR, 8'h80);
    eclk_lvl <= 1'b1;
    sysclk_lvl <= 1'b0;
    sw_sb <= 1'b1;
    wait_n(3);
    chk({6'h00, tpin.out[7:6]}, 8'h01);
    chk({6'h00, tmr_init, sci_init}, 8'h03);
    chk(tpin.pull, 8'h3f);
    sw_sb <= 1'b0;
    $display("Test expanded mode done");
    wr_reg(`TSIO_SDDR_ADDR, 8'h00);
    wr_reg(`TSIO_SDR_ADDR, 8'h3f);
    sci_ch[0] <= 6'b111010;
    sci_ch[1] <= 6'b000100;
    {s_ext, s_ext_en} <= {6'h10, 6'h12};
    wait_n(8);
    chk({2'b00, spin.oe_n}, 8'h1e);
    chk({2'b00, spin.pull}, 8'h1e);
    chk({2'b00, spin.out} & 8'h21, 8'h01);
    chk({4'h0, sci_in}, 8'h09);
    wr_reg(`TSIO_SDDR_ADDR, 8'h02);
    wait_n(2);
    chk({2'b00, spin.pull}, 8'h1c);
    chk({2'b00, spin.oe_n}, 8'h1e);
    sw_sb <= 1'b1;
    wait_n(3);
    chk({2'b00, spin.oe_n}, 8'h3d);
    chk({2'b00, spin.out} & 8'h02, 8'h02);
    chk({2'b00, spin.pull}, 8'h3d);
    sw_sb <= 1'b0;
    $display("Test serial port done");
    sci_ch[0] <= '0;
    sci_ch[1] <= '0;
    hw_sb <= 1'b1;
    wait_n(3);
    chk(tpin.oe_n, 8'hff);
    chk(tpin.pull, 8'h00);
    chk({2'b00, spin.oe_n}, 8'h3f);
    chk({2'b00, spin.pull}, 8'h00);
    hw_sb <= 1'b0;
    {s_ext, s_ext_en} <= {6'h2a, 6'h3f};
    wait_n(8);
    rd_chk(`TSIO_SDR_ADDR, 8'hea);
    $display("Test hardware standby done");
    stop_test();
  end
endmodule

`default_nettype wire
